//--- design/csw_clock_switch.sv
// clock source switch: internal oscillator model, source select,
// two-edge handover, rate dividers, clock-out pin control, wishbone
// assumes a 250 MHz core clock; oscillator clocks appear as edges
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - bus clock is source divided by four
// - four internal rates, 4 MHz after reset
// - source rate clock equals selected source
// - half rate clock is source halved
// - stop disables oscillators unless kept running
// - signed trim, larger value longer period
// - external source enables input, crystal output
// - two external rising edges before switching
// - set engaged first, then stop internal
// - clearing selection returns to internal rate
// - direct clock forces pin enable off
// - crystal owns output pin, enable ignored
// - internal source drives clock on pin when enabled
// - rc source pin general unless enabled
// - pin enable lives in pull register
// - source select encoding, resets internal
// - internal rate select encoding, resets 4 MHz
// - engaged reads one while external drives
// - request cleared by reset, monitor ignores
module csw_clock_switch
   import csw_pkg::*;
#(
   parameter int unsigned ACC_W = 24
) (
   // clock and reset
   input  wire logic        CORE_CLK_I,
   input  wire logic        RST_B_I,
   // wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output var  logic [31:0] WB_DAT_O,
   output var  logic        WB_ACK_O,
   // system integration unit
   input  wire logic        STOP_OSC_EN_I,
   input  wire logic        OSC_KEEP_IN_STOP_I,
   input  wire logic        MONITOR_BYPASS_I,
   // pins
   input  wire logic        CLK_IN_PIN_I,
   output var  logic        CLK_IN_EN_O,
   output var  logic        CLK_OUT_PIN_O,
   output var  logic        CLK_OUT_PIN_OE_O,
   output var  logic        CLK_OUT_OWNED_O,
   // oscillator controls
   output var  logic        INT_OSC_RUN_O,
   output var  logic        EXT_OSC_RUN_O,
   output var  logic        XTAL_AMP_EN_O,
   output var  logic [1:0]  XTAL_RANGE_O,
   output var  logic [7:0]  TRIM_O,
   output var  logic [6:0]  PULL_EN_O,
   // derived clocks
   output var  csw_clk_t    CLKS_O
);

   // ==========================================================
   // elaboration check
   if (ACC_W < 20 || ACC_W > 28) begin : g_bad_acc
      $error("accumulator width must be 20 to 28");
   end

   function automatic logic [31:0] base_inc(input int unsigned khz);
      longint unsigned v;
      v = (64'd2 * 64'(khz) * (64'd1 << ACC_W)) / 64'(CSW_CORE_KHZ);
      return v[31:0];
   endfunction

   // ==========================================================
   // state
   csw_ctrl_t         ctrl_q;
   logic [7:0]        trim_q;
   logic [7:0]        pull_q;
   csw_state_t        st_q;
   logic [1:0]        ecnt_q;
   logic              eng_q;
   logic [ACC_W-1:0]  acc_q;
   logic [31:0]       inc_q;
   logic signed [31:0] inc_d;
   logic [ACC_W:0]    acc_sum;
   logic              int_lvl_q;
   logic              int_run_q;
   logic [1:0]        div_q;
   logic              pin_lvl;
   logic              pin_rise;
   logic              src_lvl;
   logic              src_rise;
   logic              int_rise;
   logic              osc_ok;
   logic              wb_req;
   logic              wb_wr;
   logic [1:0]        tick_cnt_q;

   assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign wb_wr  = wb_req && WB_WE_I && WB_SEL_I[0];

   // ==========================================================
   // pin synchroniser
   csw_pin_sync u_pin_sync (
      .clk_i   (CORE_CLK_I),
      .rst_b_i (RST_B_I),
      .pin_i   (CLK_IN_PIN_I),
      .level_o (pin_lvl),
      .rise_o  (pin_rise)
   );

   // ==========================================================
   // wishbone registers
   // source select resets internal
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ctrl_q <= csw_ctrl_t'(CSW_CTRL_RST);
      end else if (wb_wr && WB_ADR_I == CSW_CTRL_OFS) begin
         ctrl_q <= csw_ctrl_t'(WB_DAT_I[6:0]);
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         trim_q <= CSW_TRIM_RST;
      end else if (wb_wr && WB_ADR_I == CSW_TRIM_OFS) begin
         trim_q <= WB_DAT_I[7:0];
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         pull_q <= CSW_PULL_RST;
      end else begin
         if (wb_wr && WB_ADR_I == CSW_PULL_OFS) begin
            pull_q <= WB_DAT_I[7:0];
         end
         if (ctrl_q.src == CSW_SRC_EXT) begin
            pull_q[CSW_COUT_EN_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0;
      end else begin
         WB_ACK_O <= wb_req;
         WB_DAT_O <= 32'h0;
         if (wb_req && !WB_WE_I) begin
            case (WB_ADR_I)
               CSW_CTRL_OFS: WB_DAT_O <= {24'h0, eng_q, ctrl_q};
               CSW_TRIM_OFS: WB_DAT_O <= {24'h0, trim_q};
               CSW_PULL_OFS: WB_DAT_O <= {24'h0, pull_q};
               default:      WB_DAT_O <= 32'h0;
            endcase
         end
      end
   end

   // ==========================================================
   // internal oscillator model
   // four nominal rates
   always_comb begin
      inc_d = $signed(base_inc(CSW_FREQ_KHZ[ctrl_q.ifrq]));
      inc_d = inc_d - ((inc_d * $signed({{24{trim_q[7]}}, trim_q}))
                       >>> CSW_TRIM_SHIFT);
   end

   assign acc_sum  = {1'b0, acc_q} + inc_q[ACC_W:0];
   assign int_rise = int_run_q && acc_sum[ACC_W] && !int_lvl_q;

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         inc_q     <= 32'h0;
         acc_q     <= '0;
         int_lvl_q <= 1'b0;
      end else begin
         inc_q <= inc_d;
         if (int_run_q) begin
            acc_q <= acc_sum[ACC_W-1:0];
            if (acc_sum[ACC_W]) begin
               int_lvl_q <= !int_lvl_q;
            end
         end
      end
   end

   // ==========================================================
   // oscillator enables
   // stop unless kept running
   assign osc_ok = STOP_OSC_EN_I || OSC_KEEP_IN_STOP_I;

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         int_run_q     <= 1'b0;
         EXT_OSC_RUN_O <= 1'b0;
         XTAL_AMP_EN_O <= 1'b0;
         CLK_IN_EN_O   <= 1'b0;
      end else begin
         int_run_q     <= osc_ok && st_q != CSW_ST_EXT;
         EXT_OSC_RUN_O <= osc_ok && ctrl_q.src[1];
         XTAL_AMP_EN_O <= osc_ok && ctrl_q.src == CSW_SRC_XTAL;
         CLK_IN_EN_O   <= ctrl_q.src != CSW_SRC_INT;
      end
   end

   assign INT_OSC_RUN_O = int_run_q;
   assign XTAL_RANGE_O  = ctrl_q.xrng;
   assign TRIM_O        = trim_q;
   assign PULL_EN_O     = pull_q[6:0];

   // ==========================================================
   // switch sequencer
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         st_q   <= CSW_ST_INT;
         ecnt_q <= 2'h0;
         eng_q  <= 1'b0;
      end else begin
         case (st_q)
            CSW_ST_INT: begin
               ecnt_q <= 2'h0;
               if (ctrl_q.req && ctrl_q.src != CSW_SRC_INT
                   && !MONITOR_BYPASS_I) begin
                  st_q <= CSW_ST_WAIT;
               end
            end
            CSW_ST_WAIT: begin
               if (!ctrl_q.req || ctrl_q.src == CSW_SRC_INT) begin
                  st_q <= CSW_ST_INT;
               end else if (pin_rise) begin
                  ecnt_q <= ecnt_q + 2'h1;
                  if (ecnt_q == CSW_EDGES_NEEDED - 2'h1) begin
                     st_q  <= CSW_ST_EXT;
                     eng_q <= 1'b1;
                  end
               end
            end
            CSW_ST_EXT: begin
               if (!ctrl_q.req || ctrl_q.src == CSW_SRC_INT) begin
                  st_q  <= CSW_ST_INT;
                  eng_q <= 1'b0;
               end
            end
            default: begin
               st_q  <= CSW_ST_INT;
               eng_q <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // source mux and dividers
   // source rate follows selection
   assign src_lvl  = eng_q ? pin_lvl : int_lvl_q;
   assign src_rise = eng_q ? pin_rise : int_rise;

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         div_q  <= 2'h0;
         CLKS_O <= '0;
      end else begin
         if (src_rise) begin
            div_q <= div_q + 2'h1;
         end
         CLKS_O.src_clk   <= src_lvl;
         CLKS_O.half_clk  <= div_q[0];
         CLKS_O.bus_clk   <= div_q[1];
         CLKS_O.src_tick  <= src_rise;
         CLKS_O.half_tick <= src_rise && div_q[0];
         CLKS_O.bus_tick  <= src_rise && div_q == 2'h3;
      end
   end

   // ==========================================================
   // clock-out pin
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         CLK_OUT_PIN_O    <= 1'b0;
         CLK_OUT_PIN_OE_O <= 1'b0;
         CLK_OUT_OWNED_O  <= 1'b0;
      end else begin
         case (ctrl_q.src)
            CSW_SRC_EXT: begin
               CLK_OUT_PIN_O    <= 1'b0;
               CLK_OUT_PIN_OE_O <= 1'b0;
               CLK_OUT_OWNED_O  <= 1'b0;
            end
            CSW_SRC_XTAL: begin
               CLK_OUT_PIN_O    <= !pin_lvl;
               CLK_OUT_PIN_OE_O <= 1'b1;
               CLK_OUT_OWNED_O  <= 1'b1;
            end
            default: begin
               CLK_OUT_PIN_O    <= pull_q[CSW_COUT_EN_BIT] && src_lvl;
               CLK_OUT_PIN_OE_O <= pull_q[CSW_COUT_EN_BIT];
               CLK_OUT_OWNED_O  <= pull_q[CSW_COUT_EN_BIT];
            end
         endcase
      end
   end

   // ==========================================================
   // checks
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         tick_cnt_q <= 2'h0;
      end else if (CLKS_O.src_tick) begin
         tick_cnt_q <= CLKS_O.bus_tick ? 2'h0 : tick_cnt_q + 2'h1;
      end
   end

   a_bus_quarter: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CLKS_O.bus_tick |-> CLKS_O.src_tick && tick_cnt_q == 2'h3)
      else $error("bus tick not on fourth source edge");

   a_half_rate: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CLKS_O.bus_tick |-> CLKS_O.half_tick)
      else $error("bus tick without half tick");

   a_stop_osc_off: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      !STOP_OSC_EN_I && !OSC_KEEP_IN_STOP_I
      |=> !INT_OSC_RUN_O && !EXT_OSC_RUN_O)
      else $error("oscillator left running in stop");

   a_clk_in_enable: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      ctrl_q.src != CSW_SRC_INT |=> CLK_IN_EN_O)
      else $error("clock input not enabled");

   a_two_edges: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      $rose(eng_q) |-> $past(pin_rise) && $past(ecnt_q) == 2'h1)
      else $error("engaged before second edge");

   a_engage_order: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      $rose(eng_q) && $past(osc_ok) |-> INT_OSC_RUN_O ##1 !INT_OSC_RUN_O)
      else $error("internal stopped out of order");

   a_return_int: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      st_q == CSW_ST_EXT && !ctrl_q.req && osc_ok && STOP_OSC_EN_I
      |=> !eng_q ##1 INT_OSC_RUN_O)
      else $error("no return to internal source");

   a_ext_pin_free: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      ctrl_q.src == CSW_SRC_EXT |=> !CLK_OUT_PIN_OE_O
      && !pull_q[CSW_COUT_EN_BIT])
      else $error("pin driven with direct clock");

   a_xtal_pin_own: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      ctrl_q.src == CSW_SRC_XTAL |=> CLK_OUT_PIN_OE_O
      && CLK_OUT_PIN_O == !$past(pin_lvl))
      else $error("crystal pin not amplifier output");

   a_int_clk_out: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      ctrl_q.src == CSW_SRC_INT && pull_q[CSW_COUT_EN_BIT]
      |=> CLK_OUT_PIN_OE_O && CLK_OUT_PIN_O == $past(src_lvl))
      else $error("source clock not on pin");

   a_rc_pin_gpio: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      ctrl_q.src == CSW_SRC_RC && !pull_q[CSW_COUT_EN_BIT]
      |=> !CLK_OUT_PIN_OE_O && !CLK_OUT_OWNED_O)
      else $error("rc pin taken without enable");

   a_monitor_ignore: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      st_q == CSW_ST_INT && MONITOR_BYPASS_I |=> st_q == CSW_ST_INT)
      else $error("request honoured in monitor mode");

   a_no_edge_stay: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      st_q == CSW_ST_WAIT && !pin_rise |=> !eng_q)
      else $error("engaged without external edge");

   a_engaged_state: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      eng_q == (st_q == CSW_ST_EXT))
      else $error("engaged flag disagrees with state");

endmodule // csw_clock_switch
`default_nettype wire

//--- design/csw_pin_sync.sv
// three-flop pin synchroniser with agreement filter and rise pulse
// assumes an asynchronous pin and the core clock domain
`timescale 1ns/1ps
`default_nettype none
module csw_pin_sync (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   // pin and result
   input  wire logic pin_i,
   output var  logic level_o,
   output var  logic rise_o
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // ==========================================================
   // synchroniser chain
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ==========================================================
   // level accepted once second and third agree
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         level_o <= 1'b0;
         rise_o  <= 1'b0;
      end else begin
         rise_o <= (s2_q == s3_q) && s3_q && !level_o;
         if (s2_q == s3_q) begin
            level_o <= s3_q;
         end
      end
   end
endmodule // csw_pin_sync
`default_nettype wire

//--- design/csw_pkg.sv
// clock source switch: shared constants, field layouts and types
// assumes a 250 MHz core clock and an 8-bit-wide register view
package csw_pkg;

   // ==========================================================
   // timing
   localparam int unsigned CSW_CORE_KHZ = 250000;
   localparam int unsigned CSW_FREQ_KHZ [4] = '{4000, 8000, 12800, 25600};
   localparam int unsigned CSW_TRIM_SHIFT = 9;
   localparam logic [1:0]  CSW_EDGES_NEEDED = 2'h2;

   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] CSW_CTRL_OFS = 8'h00;
   localparam logic [7:0] CSW_TRIM_OFS = 8'h04;
   localparam logic [7:0] CSW_PULL_OFS = 8'h08;

   // ==========================================================
   // field positions and reset values
   localparam int unsigned CSW_ENG_BIT     = 7;
   localparam int unsigned CSW_COUT_EN_BIT = 7;
   localparam logic [6:0]  CSW_CTRL_RST    = 7'h00;
   localparam logic [7:0]  CSW_TRIM_RST    = 8'h00;
   localparam logic [7:0]  CSW_PULL_RST    = 8'h00;

   // ==========================================================
   // source encodings
   localparam logic [1:0] CSW_SRC_INT  = 2'h0;
   localparam logic [1:0] CSW_SRC_EXT  = 2'h1;
   localparam logic [1:0] CSW_SRC_RC   = 2'h2;
   localparam logic [1:0] CSW_SRC_XTAL = 2'h3;

   // ==========================================================
   // types
   typedef struct packed {
      logic       req;
      logic [1:0] ifrq;
      logic [1:0] xrng;
      logic [1:0] src;
   } csw_ctrl_t;

   typedef struct packed {
      logic src_clk;
      logic half_clk;
      logic bus_clk;
      logic src_tick;
      logic half_tick;
      logic bus_tick;
   } csw_clk_t;

   typedef enum logic [1:0] {
      CSW_ST_INT,
      CSW_ST_WAIT,
      CSW_ST_EXT
   } csw_state_t;

endpackage

//--- tb/csw_ext_src.sv
// far-side model: external clock source feeding the clock input pin
// assumes the bench enables it; the pin stands still low while idle
`timescale 1ns/1ps
`default_nettype none
module csw_ext_src #(
   parameter int HALF_NS = 40
) (
   // control and pin
   input  wire logic run_i,
   output var  logic pin_o
);
   // ==========================================================
   // source toggles while run_i is high, held low otherwise
   // supplies the rising edges the switch waits for
   initial begin
      pin_o = 1'b0;
      forever begin
         #(HALF_NS);
         if (run_i) begin
            pin_o = ~pin_o;
         end else begin
            pin_o = 1'b0;
         end
      end
   end
endmodule // csw_ext_src
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the clock source switch
// assumes a 250 MHz core clock and one external clock source model
`timescale 1ns/1ps
`default_nettype none
module tb;
   import csw_pkg::*;
   // ==========================================================
   // signals
   logic        clk, rst_b, cyc, stb, we, stop_en, keep, mon, ext_run, ack, in_en;
   logic        cpin, coe, cown, irun, erun, amp;
   logic [7:0]  adr, trim, rd;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic [1:0]  xr;
   logic [6:0]  pull;
   csw_clk_t    clks;
   wire logic   pin;
   int          fail_count, total_checks;
   int          s, h, b;

   csw_ext_src #(.HALF_NS(40)) u_src (.run_i(ext_run), .pin_o(pin));
   csw_clock_switch dut (
      .CORE_CLK_I(clk), .RST_B_I(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .STOP_OSC_EN_I(stop_en),
      .OSC_KEEP_IN_STOP_I(keep), .MONITOR_BYPASS_I(mon), .CLK_IN_PIN_I(pin),
      .CLK_IN_EN_O(in_en), .CLK_OUT_PIN_O(cpin), .CLK_OUT_PIN_OE_O(coe),
      .CLK_OUT_OWNED_O(cown), .INT_OSC_RUN_O(irun), .EXT_OSC_RUN_O(erun),
      .XTAL_AMP_EN_O(amp), .XTAL_RANGE_O(xr), .TRIM_O(trim), .PULL_EN_O(pull),
      .CLKS_O(clks));

   always #2 clk = ~clk;

   // ==========================================================
   // shared tasks
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic near(input string n, input int e, input int g, input int tol);
      total_checks++;
      if (g < e - tol || g > e + tol) begin
         fail_count++;
         $display("BAD %s expected %0d seen %0d", n, e, g);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= 4'h1;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(n, {24'h0, e}, {24'h0, rd});
   endtask

   task automatic ticks(input int n);
      int bad;
      s = 0; h = 0; b = 0; bad = 0;
      repeat (n) begin
         @(posedge clk);
         s += (clks.src_tick === 1'b1);
         h += (clks.half_tick === 1'b1);
         b += (clks.bus_tick === 1'b1);
         if (clks.bus_tick === 1'b1 && (clks.src_tick !== 1'b1 || clks.half_tick !== 1'b1))
            bad++;
      end
      chk("tick_align", 32'h0, bad);
      near("half_rate", s / 2, h, 1);
      near("bus_rate", s / 4, b, 1);
   endtask

   task automatic close_out();
      if (fail_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      rdchk("ctrl_rst", CSW_CTRL_OFS, 8'h00);
      rdchk("trim_rst", CSW_TRIM_OFS, CSW_TRIM_RST);
      rdchk("pull_rst", CSW_PULL_OFS, CSW_PULL_RST);
      rdchk("unmapped", 8'h0c, 8'h00);
      chk("int_run_rst", 1, irun);
   endtask

   task automatic t_trim();
      int slow;
      // software loads the trim value itself
      wb(1'b1, CSW_TRIM_OFS, 8'h7f);
      rdchk("trim_max", CSW_TRIM_OFS, 8'h7f);
      repeat (20) @(posedge clk);
      ticks(2500);
      slow = s;
      chk("trim_below_nominal", 1, slow < 38);
      wb(1'b1, CSW_TRIM_OFS, 8'h80);
      chk("trim_out", 8'h80, trim);
      repeat (20) @(posedge clk);
      ticks(2500);
      chk("trim_slower", 1, slow < s);
      wb(1'b1, CSW_TRIM_OFS, 8'h00);
   endtask

   task automatic t_rates();
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, CSW_CTRL_OFS, 8'(i << 4));
         repeat (100) @(posedge clk);
         ticks(2500);
         near("int_rate", CSW_FREQ_KHZ[i] * 2500 / CSW_CORE_KHZ, s, 2);
      end
      wb(1'b1, CSW_CTRL_OFS, 8'h00);
   endtask

   task automatic t_pin();
      int bad;
      int hi;
      wb(1'b1, CSW_PULL_OFS, 8'h85);
      repeat (3) @(posedge clk);
      chk("oe_int", 1, coe);
      chk("pull_low", 7'h05, pull);
      chk("own_int", 1, cown);
      bad = 0;
      hi = 0;
      repeat (200) begin
         @(posedge clk);
         bad += (cpin !== clks.src_clk);
         hi += (cpin === 1'b1);
      end
      chk("pin_clk_int", 0, bad);
      chk("pin_clk_toggles", 1, hi > 0 && hi < 200);
      wb(1'b1, CSW_CTRL_OFS, 8'h02);
      repeat (3) @(posedge clk);
      chk("oe_rc_on", 1, coe);
      wb(1'b1, CSW_PULL_OFS, 8'h00);
      repeat (3) @(posedge clk);
      chk("oe_rc_off", 0, coe);
      chk("own_rc_off", 0, cown);
      // crystal picked with range one after the pin enable is cleared
      wb(1'b1, CSW_CTRL_OFS, 8'h07);
      repeat (3) @(posedge clk);
      chk("oe_xtal", 1, coe);
      chk("pin_xtal_inv", 1, cpin);
      chk("amp_xtal", 1, amp);
      chk("erun_xtal", 1, erun);
      chk("xrange", 2'h1, xr);
      wb(1'b1, CSW_CTRL_OFS, 8'h00);
   endtask

   task automatic t_switch();
      int n;
      wb(1'b1, CSW_PULL_OFS, 8'h80);
      wb(1'b1, CSW_CTRL_OFS, 8'h01);
      repeat (3) @(posedge clk);
      chk("in_en_ext", 1, in_en);
      chk("oe_ext", 0, coe);
      rdchk("pull_forced", CSW_PULL_OFS, 8'h00);
      wb(1'b1, CSW_CTRL_OFS, 8'h41);
      repeat (300) @(posedge clk);
      rdchk("no_edges", CSW_CTRL_OFS, 8'h41);
      chk("int_kept", 1, irun);
      ext_run <= 1'b1;
      n = 0;
      do begin
         wb(1'b0, CSW_CTRL_OFS, 8'h00);
         n++;
      end while (rd[CSW_ENG_BIT] !== 1'b1 && n < 40);
      chk("engaged", 8'hc1, rd);
      repeat (3) @(posedge clk);
      chk("int_stop", 0, irun);
      ticks(800);
      near("ext_rate", 40, s, 2);
      wb(1'b1, CSW_CTRL_OFS, 8'h00);
      repeat (4) @(posedge clk);
      chk("int_back", 1, irun);
      rdchk("disengaged", CSW_CTRL_OFS, 8'h00);
   endtask

   task automatic t_midreset();
      wb(1'b1, CSW_CTRL_OFS, 8'h41);
      repeat (100) @(posedge clk);
      rdchk("eng_again", CSW_CTRL_OFS, 8'hc1);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rdchk("req_cleared", CSW_CTRL_OFS, 8'h00);
      chk("int_after_rst", 1, irun);
   endtask

   task automatic t_monitor();
      mon <= 1'b1;
      wb(1'b1, CSW_CTRL_OFS, 8'h41);
      repeat (300) @(posedge clk);
      rdchk("mon_ignore", CSW_CTRL_OFS, 8'h41);
      wb(1'b1, CSW_CTRL_OFS, 8'h00);
      mon     <= 1'b0;
      ext_run <= 1'b0;
   endtask

   task automatic t_stop();
      stop_en <= 1'b0;
      repeat (4) @(posedge clk);
      chk("stop_off", 0, irun);
      ticks(300);
      chk("stop_ticks", 0, s);
      keep <= 1'b1;
      repeat (4) @(posedge clk);
      chk("keep_on", 1, irun);
      stop_en <= 1'b1;
      keep    <= 1'b0;
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial begin
      clk = 1'b0; rst_b = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
      adr = 8'h00; sel = 4'h0; wdat = 32'h0; stop_en = 1'b1; keep = 1'b0;
      mon = 1'b0; ext_run = 1'b0; fail_count = 0; total_checks = 0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_trim();
      t_rates();
      t_pin();
      t_switch();
      ext_run <= 1'b1;
      t_midreset();
      t_monitor();
      t_stop();
      close_out();
   end

   initial begin
      #160000;
      fail_count++;
      close_out();
   end
endmodule // tb
`default_nettype wire
